// [hw/lcdtm_top.sv]
// Functional notes
// - registers decode at display base plus 1FFE0h plus register number
// - 80 kilobyte display buffer inside; system logic places its base
// - power-up clears every control register to zero
// - displayed pixels per line are (width register plus one) times eight
// - displayed lines are the 06/05 register pair plus one
// - horizontal blanking pixels are (blanking register plus four) times eight
// - vertical blanking lines equal the blanking register directly
// - vertical blanking reaches up to sixty-three lines
// - single or active-matrix frame is total pixels times total lines
// - dual passive frame is twice line length times half lines plus blanking
// - pixel clock is input clock divided by one, two, four or eight
// - line and frame pulse start positions apply to active-matrix only
// - modulation rate matters only for monochrome passive panels
// - panel value 23h selects passive single color 8-bit panel
// - mode value C0h selects eight bits per pixel
// - power value 03h selects normal operation
// - screen start addresses join two low bytes and upper bits at 10h
// - maximum screen 1 vertical size means no split onto screen 2
// - zero pitch offset means line pitch equals visible width
// - zero rotation is landscape; line byte count used only in portrait
// - sub-byte pixels are taken most significant bits first
// - palette data accesses step red, green, blue after index write
`timescale 1ns/1ps
`default_nettype none
module lcdtm_top #(
    parameter int unsigned MEM_BYTES = lcdtm_pkg::MEM_BYTES,
    parameter int unsigned PIX_W = 12
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // processor access
    input wire logic [16:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // panel side
    output logic panel_line_pulse_o,
    output logic panel_frame_pulse_o,
    output logic panel_modulation_o,
    output logic [PIX_W-1:0] pix_data_o,
    output logic pix_valid_o,
    input wire logic pix_ready_i,
    // general pins
    input wire logic [7:0] gpio_i,
    output logic [7:0] gpio_o,
    output logic [7:0] gpio_oe_o
);
    logic [7:0] regs_r [lcdtm_pkg::REG_COUNT];
    logic [7:0] vram [MEM_BYTES];
    logic [11:0] pal [256];
    logic [7:0] pal_idx_r;
    logic [1:0] pal_comp_r;
    logic [7:0] rdata_r;
    logic rvalid_r;
    logic [12:0] h_r;
    logic [10:0] v_r;
    logic [16:0] ptr_r;
    logic [16:0] line_base_r;
    logic [2:0] sub_r;
    logic line_pulse_r;
    logic frame_pulse_r;
    logic mod_r;
    logic [7:0] mod_cnt_r;

    // access decode
    wire logic reg_sel_w = (addr_i[16:5] == lcdtm_pkg::REG_BASE[16:5]);
    wire logic [4:0] reg_idx_w = addr_i[4:0];
    wire logic mem_sel_w = (32'(addr_i) < MEM_BYTES);
    wire logic reg_we_w = ce_i && we_i && reg_sel_w;
    wire logic mem_we_w = ce_i && we_i && mem_sel_w;
    wire logic pal_idx_we_w = reg_we_w && reg_idx_w == lcdtm_pkg::OFS_PAL_INDEX;
    wire logic pal_acc_w = ce_i && reg_sel_w && reg_idx_w == lcdtm_pkg::OFS_PAL_DATA
        && (we_i || re_i);

    genvar g;
    generate
        for (g = 0; g < lcdtm_pkg::REG_COUNT; g++) begin : g_reg
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    regs_r[g] <= lcdtm_pkg::REG_RESET;
                end else if (reg_we_w && reg_idx_w == 5'(g)) begin
                    regs_r[g] <= wdata_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (mem_we_w) vram[addr_i] <= wdata_i;
    end

    // palette write port and component stepping
    always_ff @(posedge clk_i) begin
        if (pal_acc_w && we_i) begin
            case (pal_comp_r)
                2'h0: pal[pal_idx_r][11:8] <= wdata_i[7:4];
                2'h1: pal[pal_idx_r][7:4] <= wdata_i[7:4];
                default: pal[pal_idx_r][3:0] <= wdata_i[7:4];
            endcase
        end
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pal_idx_r <= 8'h00;
            pal_comp_r <= 2'h0;
        end else if (pal_idx_we_w) begin
            pal_idx_r <= wdata_i;
            pal_comp_r <= 2'h0;
        end else if (pal_acc_w) begin
            pal_comp_r <= (pal_comp_r == lcdtm_pkg::PAL_BLUE) ? 2'h0 : pal_comp_r + 2'h1;
            if (pal_comp_r == lcdtm_pkg::PAL_BLUE) pal_idx_r <= pal_idx_r + 8'h01;
        end
    end

    // read data
    wire logic [11:0] pal_rd_w = pal[pal_idx_r];
    wire logic [7:0] pin_cfg_w = regs_r[lcdtm_pkg::OFS_PIN_CFG];
    wire logic [7:0] pin_rd_w = (regs_r[lcdtm_pkg::OFS_PIN_STATE] & pin_cfg_w)
        | (gpio_i & ~pin_cfg_w);
    wire logic [3:0] pal_comp_rd_w = (pal_comp_r == 2'h0) ? pal_rd_w[11:8] :
        (pal_comp_r == 2'h1) ? pal_rd_w[7:4] : pal_rd_w[3:0];
    wire logic [7:0] reg_rd_w = (reg_idx_w == lcdtm_pkg::OFS_PAL_INDEX) ? pal_idx_r :
        (reg_idx_w == lcdtm_pkg::OFS_PAL_DATA) ? {pal_comp_rd_w, 4'h0} :
        (reg_idx_w == lcdtm_pkg::OFS_PIN_STATE) ? pin_rd_w : regs_r[reg_idx_w];
    wire logic [7:0] rd_mux_w = reg_sel_w ? reg_rd_w : (mem_sel_w ? vram[addr_i] : 8'h00);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else if (ce_i) begin
            rvalid_r <= re_i;
            if (re_i) rdata_r <= rd_mux_w;
        end
    end
    assign rdata_o = rdata_r;
    assign rvalid_o = rvalid_r;
    assign gpio_o = regs_r[lcdtm_pkg::OFS_PIN_STATE];
    assign gpio_oe_o = pin_cfg_w;

    // configuration fields
    wire logic [7:0] panel_w = regs_r[lcdtm_pkg::OFS_PANEL];
    wire logic am_w = panel_w[lcdtm_pkg::PANEL_AM_BIT];
    wire logic dual_w = !am_w && panel_w[lcdtm_pkg::PANEL_DUAL_BIT];
    wire logic mono_w = panel_w[lcdtm_pkg::PANEL_MONO_BIT];
    wire logic [1:0] bpp_w = regs_r[lcdtm_pkg::OFS_MODE][lcdtm_pkg::MODE_BPP_MSB:
        lcdtm_pkg::MODE_BPP_LSB];
    wire logic powered_w = regs_r[lcdtm_pkg::OFS_POWER][1:0] == lcdtm_pkg::POWER_NORMAL;
    wire logic pix_tick_w;

    lcdtm_clkdiv u_div (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .sel_i(regs_r[lcdtm_pkg::OFS_MODE][1:0]),
        .tick_o(pix_tick_w)
    );

    // period arithmetic
    wire logic [12:0] hdp_w = 13'({5'h00, regs_r[lcdtm_pkg::OFS_HWIDTH]} + 13'h1)
        << lcdtm_pkg::HDP_SHIFT;
    wire logic [12:0] horizontal_blank_period_w = 13'({1'b0, regs_r[lcdtm_pkg::OFS_HBLANK][4:0]}
        + lcdtm_pkg::HORIZONTAL_BLANK_PERIOD_ADD) << lcdtm_pkg::HDP_SHIFT;
    wire logic [12:0] htot_w = 13'(hdp_w + horizontal_blank_period_w);
    wire logic [12:0] hline_w = dual_w ? 13'(htot_w << 1) : htot_w;
    wire logic [12:0] hdisp_w = dual_w ? 13'(hdp_w << 1) : hdp_w;
    wire logic [10:0] vdp_w = 11'({regs_r[lcdtm_pkg::OFS_VHEIGHT_HI][1:0],
        regs_r[lcdtm_pkg::OFS_VHEIGHT_LO]} + 11'h1);
    wire logic [10:0] vertical_blank_period_w = {5'h00, regs_r[lcdtm_pkg::OFS_VBLANK][5:0]};
    wire logic [10:0] vdisp_w = dual_w ? (vdp_w >> 1) : vdp_w;
    wire logic [10:0] vtot_w = 11'(vdisp_w + vertical_blank_period_w);

    // counters and stream handshake
    lcdtm_stream_if #(.W(PIX_W)) pix_in ();
    lcdtm_stream_if #(.W(PIX_W)) pix_out ();
    wire logic in_disp_w = (h_r < hdisp_w) && (v_r < vdisp_w);
    wire logic slot_w = ce_i && pix_tick_w && powered_w;
    wire logic adv_w = slot_w && (!in_disp_w || pix_in.ready);
    wire logic hwrap_w = (h_r >= 13'(hline_w - 13'h1));
    wire logic vwrap_w = (v_r >= 11'(vtot_w - 11'h1));

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            h_r <= 13'h0000;
            v_r <= 11'h000;
        end else if (ce_i && !powered_w) begin
            h_r <= 13'h0000;
            v_r <= 11'h000;
        end else if (adv_w) begin
            h_r <= hwrap_w ? 13'h0000 : h_r + 13'h1;
            if (hwrap_w) v_r <= vwrap_w ? 11'h000 : v_r + 11'h1;
        end
    end

    // fetch addressing
    wire logic [16:0] start1_w = {regs_r[lcdtm_pkg::OFS_S_UPPER][lcdtm_pkg::S1_UPPER_BIT],
        regs_r[lcdtm_pkg::OFS_S1_MID], regs_r[lcdtm_pkg::OFS_S1_LO]};
    wire logic [16:0] start2_w = {regs_r[lcdtm_pkg::OFS_S_UPPER][lcdtm_pkg::S2_UPPER_BIT],
        regs_r[lcdtm_pkg::OFS_S2_MID], regs_r[lcdtm_pkg::OFS_S2_LO]};
    wire logic [9:0] s1_vsize_w = {regs_r[lcdtm_pkg::OFS_S1_VSIZE_HI][1:0],
        regs_r[lcdtm_pkg::OFS_S1_VSIZE_LO]};
    wire logic split_w = (s1_vsize_w != lcdtm_pkg::S1_VSIZE_MAX)
        && (11'(v_r + 11'h1) == 11'({1'b0, s1_vsize_w} + 11'h1));
    wire logic rot_w = regs_r[lcdtm_pkg::OFS_ROTATE][lcdtm_pkg::ROT_EN_BIT];
    wire logic [7:0] ofs_w = regs_r[lcdtm_pkg::OFS_PITCH];
    wire logic [16:0] width_bytes_w = 17'({9'h000, regs_r[lcdtm_pkg::OFS_HWIDTH]}
        + 17'h1) << bpp_w;
    wire logic [16:0] pitch_w = rot_w ? {9'h000, regs_r[lcdtm_pkg::OFS_ROT_BYTES]} :
        (ofs_w == 8'h00) ? width_bytes_w : {8'h00, ofs_w, 1'b0};
    wire logic [16:0] next_base_w = vwrap_w ? start1_w :
        split_w ? start2_w : 17'(line_base_r + pitch_w);
    // pixels per byte: 8, 4, 2 or 1
    wire logic [3:0] ppb_w = 4'h8 >> bpp_w;
    wire logic [2:0] last_sub_w = 3'(ppb_w - 4'h1);
    wire logic [2:0] last_w = (bpp_w == 2'h3) ? 3'h0 : last_sub_w;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ptr_r <= 17'h00000;
            line_base_r <= 17'h00000;
            sub_r <= 3'h0;
        end else if (ce_i && !powered_w) begin
            ptr_r <= start1_w;
            line_base_r <= start1_w;
            sub_r <= 3'h0;
        end else if (adv_w && hwrap_w) begin
            ptr_r <= next_base_w;
            line_base_r <= next_base_w;
            sub_r <= 3'h0;
        end else if (adv_w && in_disp_w) begin
            sub_r <= (sub_r >= last_w) ? 3'h0 : sub_r + 3'h1;
            if (sub_r >= last_w) ptr_r <= 17'(ptr_r + 17'h1);
        end
    end

    // pixel extraction, leftmost pixel in the top bits
    wire logic [7:0] fetch_w = (32'(ptr_r) < MEM_BYTES) ? vram[ptr_r] : 8'h00;
    wire logic [2:0] sh_w = 3'(sub_r << bpp_w);
    wire logic [7:0] sb_w = 8'(fetch_w << sh_w);
    wire logic [7:0] pidx_w = (bpp_w == 2'h0) ? {7'h00, sb_w[7]} :
        (bpp_w == 2'h1) ? {6'h00, sb_w[7:6]} :
        (bpp_w == 2'h2) ? {4'h0, sb_w[7:4]} : sb_w;
    wire logic [11:0] color_w = pal[pidx_w];
    assign pix_in.valid = slot_w && in_disp_w;
    assign pix_in.data = PIX_W'(mono_w ? {4'h0, color_w[7:4], 4'h0} : color_w);

    lcdtm_buf2 #(.W(PIX_W)) u_buf (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .in_s(pix_in),
        .out_s(pix_out)
    );
    assign pix_out.ready = pix_ready_i;
    assign pix_data_o = pix_out.data;
    assign pix_valid_o = pix_out.valid;

    // panel pulses and modulation
    wire logic [12:0] lp_pos_w = am_w ? 13'(hdisp_w
        + {5'h00, regs_r[lcdtm_pkg::OFS_LINE_START]}) : hdisp_w;
    wire logic [10:0] fp_line_w = am_w ? 11'(vdisp_w
        + {3'h0, regs_r[lcdtm_pkg::OFS_FRAME_START]}) : vdisp_w;
    wire logic [7:0] mod_rate_w = regs_r[lcdtm_pkg::OFS_MOD_RATE];
    wire logic mod_use_w = mono_w && !am_w;
    wire logic mod_flip_w = (mod_rate_w == 8'h00) ? vwrap_w
        : (mod_cnt_r >= 8'(mod_rate_w - 8'h01));
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            line_pulse_r <= 1'b0;
            frame_pulse_r <= 1'b0;
            mod_r <= 1'b0;
            mod_cnt_r <= 8'h00;
        end else if (ce_i && !powered_w) begin
            line_pulse_r <= 1'b0;
            frame_pulse_r <= 1'b0;
            mod_r <= 1'b0;
            mod_cnt_r <= 8'h00;
        end else if (adv_w) begin
            line_pulse_r <= (h_r == lp_pos_w);
            frame_pulse_r <= (v_r == fp_line_w);
            if (hwrap_w && mod_use_w) begin
                mod_r <= mod_flip_w ? ~mod_r : mod_r;
                mod_cnt_r <= mod_flip_w ? 8'h00 : mod_cnt_r + 8'h01;
            end
        end
    end
    assign panel_line_pulse_o = line_pulse_r;
    assign panel_frame_pulse_o = frame_pulse_r;
    assign panel_modulation_o = mod_r && mod_use_w;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    hcount_wrap_a: assert property ((adv_w && hwrap_w) |=> h_r == 13'h0000)
        else $error("horizontal counter did not wrap");
    line_step_a: assert property ((adv_w && hwrap_w && !vwrap_w && powered_w)
        |=> v_r == $past(v_r) + 11'h1)
        else $error("line counter did not advance on wrap");
    reg_write_a: assert property ((ce_i && we_i && addr_i == 17'h1FFE4)
        |=> regs_r[lcdtm_pkg::OFS_HWIDTH] == $past(wdata_i))
        else $error("width register not written at its address");
    reset_clear_a: assert property ($rose(rstn_i) |-> regs_r[lcdtm_pkg::OFS_POWER] == 8'h00)
        else $error("register not clear after reset");
    mem_back_a: assert property ((mem_we_w ##1 (ce_i && re_i && !we_i
        && addr_i == $past(addr_i))) |=> rdata_o == $past(wdata_i, 2))
        else $error("display buffer read did not return written byte");
    pal_step_a: assert property ((pal_acc_w && !pal_idx_we_w && pal_comp_r == 2'h2)
        |=> pal_comp_r == 2'h0 && pal_idx_r == $past(pal_idx_r) + 8'h01)
        else $error("palette pointer did not step after blue");
    pulse_pos_a: assert property ((adv_w && !am_w && h_r == hdisp_w)
        |=> panel_line_pulse_o)
        else $error("passive line pulse not at end of display");
    power_quiet_a: assert property ((ce_i && !powered_w)
        |=> (h_r == 13'h0000 && v_r == 11'h000 && !panel_line_pulse_o))
        else $error("raster not held outside normal power");
    pitch_zero_a: assert property ((!rot_w && ofs_w == 8'h00)
        |-> pitch_w == 17'(({9'h000, regs_r[lcdtm_pkg::OFS_HWIDTH]} + 17'h1) << bpp_w))
        else $error("zero offset pitch differs from width");
    frame_pos_a: assert property ((adv_w && !am_w && v_r == vdisp_w)
        |=> panel_frame_pulse_o)
        else $error("passive frame pulse not after display lines");
    rd_valid_a: assert property (ce_i |=> rvalid_o == $past(re_i))
        else $error("read valid does not follow read strobe");
    raster_freeze_a: assert property (!ce_i
        |=> (h_r == $past(h_r) && v_r == $past(v_r) && ptr_r == $past(ptr_r)))
        else $error("raster moved while enable low");
    sub_step_a: assert property ((adv_w && in_disp_w && !hwrap_w && bpp_w == 2'h0
        && sub_r != 3'h7) |=> (ptr_r == $past(ptr_r) && sub_r == 3'($past(sub_r) + 3'h1)))
        else $error("one bit pixel stepping wrong");
    mod_toggle_a: assert property ((adv_w && hwrap_w && vwrap_w && mod_use_w
        && mod_rate_w == 8'h00) |=> panel_modulation_o != $past(panel_modulation_o))
        else $error("modulation did not toggle at frame end");
    frame_wrap_c: cover property (adv_w && hwrap_w && vwrap_w);
    split_c: cover property (adv_w && hwrap_w && split_w);
    stall_c: cover property (pix_in.valid && !pix_in.ready);
    pal_cycle_c: cover property (pal_acc_w && pal_comp_r == 2'h2);
endmodule
`default_nettype wire

// [hw/lcdtm_pkg.sv]
package lcdtm_pkg;
    // register window and display buffer
    localparam logic [16:0] REG_BASE = 17'h1FFE0;
    localparam int unsigned MEM_BYTES = 81920;
    localparam int unsigned REG_COUNT = 32;
    localparam logic [7:0] REG_RESET = 8'h00;
    // register offsets
    localparam logic [4:0] OFS_PANEL = 5'h01;
    localparam logic [4:0] OFS_MODE = 5'h02;
    localparam logic [4:0] OFS_POWER = 5'h03;
    localparam logic [4:0] OFS_HWIDTH = 5'h04;
    localparam logic [4:0] OFS_VHEIGHT_LO = 5'h05;
    localparam logic [4:0] OFS_VHEIGHT_HI = 5'h06;
    localparam logic [4:0] OFS_LINE_START = 5'h07;
    localparam logic [4:0] OFS_HBLANK = 5'h08;
    localparam logic [4:0] OFS_FRAME_START = 5'h09;
    localparam logic [4:0] OFS_VBLANK = 5'h0A;
    localparam logic [4:0] OFS_MOD_RATE = 5'h0B;
    localparam logic [4:0] OFS_S1_LO = 5'h0C;
    localparam logic [4:0] OFS_S1_MID = 5'h0D;
    localparam logic [4:0] OFS_S2_LO = 5'h0E;
    localparam logic [4:0] OFS_S2_MID = 5'h0F;
    localparam logic [4:0] OFS_S_UPPER = 5'h10;
    localparam logic [4:0] OFS_PITCH = 5'h11;
    localparam logic [4:0] OFS_S1_VSIZE_LO = 5'h12;
    localparam logic [4:0] OFS_S1_VSIZE_HI = 5'h13;
    localparam logic [4:0] OFS_PAL_INDEX = 5'h15;
    localparam logic [4:0] OFS_PAL_DATA = 5'h17;
    localparam logic [4:0] OFS_PIN_CFG = 5'h18;
    localparam logic [4:0] OFS_PIN_STATE = 5'h19;
    localparam logic [4:0] OFS_ROTATE = 5'h1B;
    localparam logic [4:0] OFS_ROT_BYTES = 5'h1C;
    // field positions
    localparam int unsigned PANEL_AM_BIT = 7;
    localparam int unsigned PANEL_DUAL_BIT = 6;
    localparam int unsigned PANEL_MONO_BIT = 2;
    localparam int unsigned MODE_BPP_MSB = 7;
    localparam int unsigned MODE_BPP_LSB = 6;
    localparam int unsigned ROT_EN_BIT = 7;
    localparam int unsigned S1_UPPER_BIT = 0;
    localparam int unsigned S2_UPPER_BIT = 4;
    localparam logic [1:0] POWER_NORMAL = 2'h3;
    // timing arithmetic, screen 1 size limit and last palette component
    localparam int unsigned HDP_SHIFT = 3;
    localparam logic [5:0] HORIZONTAL_BLANK_PERIOD_ADD = 6'h04;
    localparam logic [9:0] S1_VSIZE_MAX = 10'h3FF;
    localparam logic [1:0] PAL_BLUE = 2'h2;
endpackage

// [hw/lcdtm_stream_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface lcdtm_stream_if #(parameter int unsigned W = 12);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// [hw/lcdtm_clkdiv.sv]
`timescale 1ns/1ps
`default_nettype none
module lcdtm_clkdiv (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // divider select: 0 /1, 1 /2, 2 /4, 3 /8
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    logic [2:0] cnt_r;
    wire logic [2:0] last_w = 3'((4'h1 << sel_i) - 4'h1);
    assign tick_o = (cnt_r >= last_w);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 3'h0;
        end else if (ce_i) begin
            cnt_r <= tick_o ? 3'h0 : cnt_r + 3'h1;
        end
    end
    div_two_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ce_i && tick_o && sel_i == 2'h1 && $stable(sel_i)) |=> !tick_o)
        else $error("pixel tick too early for divide by two");
endmodule
`default_nettype wire

// [hw/lcdtm_buf2.sv]
`timescale 1ns/1ps
`default_nettype none
module lcdtm_buf2 #(parameter int unsigned W = 12) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // streams
    lcdtm_stream_if.snk in_s,
    lcdtm_stream_if.src out_s
);
    logic [W-1:0] ent_r [2];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    wire logic push_w = ce_i && in_s.valid && in_s.ready;
    wire logic pop_w = ce_i && out_s.valid && out_s.ready;
    assign in_s.ready = (cnt_r != 2'h2);
    assign out_s.valid = (cnt_r != 2'h0);
    assign out_s.data = ent_r[rp_r];
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push_w) wp_r <= ~wp_r;
            if (pop_w) rp_r <= ~rp_r;
            cnt_r <= 2'(cnt_r + {1'b0, push_w} - {1'b0, pop_w});
        end
    end
    always_ff @(posedge clk_i) begin
        if (push_w) ent_r[wp_r] <= in_s.data;
    end
    full_block_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (cnt_r == 2'h2 && !(ce_i && out_s.ready)) |=> !in_s.ready)
        else $error("buffer accepted while full");
    buf_full_c: cover property (@(posedge clk_i) disable iff (!rstn_i) cnt_r == 2'h2);
endmodule
`default_nettype wire

// [verification/lcdtm_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lcdtm_panel_model (
    // clock and stall control
    input wire logic clk_i,
    input wire logic stall_i,
    // panel stream
    input wire logic frame_i,
    input wire logic valid_i,
    output logic ready_o,
    output var int frame_pix_o,
    // first pixel taken after each frame pulse
    input wire logic [11:0] data_i,
    output logic [11:0] first_o
);
    int cnt = 0;
    logic fr_d = 1'b0;
    logic arm = 1'b0;
    initial begin
        ready_o = 1'b1;
        frame_pix_o = 0;
    end
    // stalling panel takes a pixel every other cycle
    always @(negedge clk_i) begin
        ready_o <= !stall_i || !ready_o;
    end
    // pixels taken between frame pulse starts
    always @(posedge clk_i) begin
        fr_d <= frame_i;
        if (frame_i && !fr_d) begin
            frame_pix_o <= cnt;
            cnt <= (valid_i && ready_o) ? 1 : 0;
            arm <= 1'b1;
        end else if (valid_i && ready_o) begin
            cnt <= cnt + 1;
            if (arm) first_o <= data_i;
            arm <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [verification/lcd_panel_timing_setup_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_timing_setup_tb;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [16:0] addr = 17'h00000;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic re = 1'b0;
    logic stall = 1'b0;
    logic ce = 1'b1;
    logic [7:0] gpio_in = 8'h5A;
    logic [7:0] rdata, gpio_out, gpio_oe;
    logic rvalid, lp, fp, modl, pv, pr;
    logic [11:0] pd, first_pix;
    int fpix;
    int c;
    int error_cnt = 0;
    int samples_checked = 0;
    always #12.5 clk_i = ~clk_i;
    lcdtm_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .addr_i(addr),
        .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .rvalid_o(rvalid),
        .panel_line_pulse_o(lp), .panel_frame_pulse_o(fp), .panel_modulation_o(modl),
        .pix_data_o(pd), .pix_valid_o(pv), .pix_ready_i(pr), .gpio_i(gpio_in),
        .gpio_o(gpio_out), .gpio_oe_o(gpio_oe));
    lcdtm_panel_model i_panel (.clk_i(clk_i), .stall_i(stall), .frame_i(fp),
        .valid_i(pv), .ready_o(pr), .frame_pix_o(fpix), .data_i(pd), .first_o(first_pix));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk_i);
        we = 1'b0;
    endtask
    task automatic rd(input logic [16:0] a, input logic [7:0] exp);
        @(negedge clk_i);
        addr = a;
        re = 1'b1;
        @(negedge clk_i);
        re = 1'b0;
        chk8({7'h00, rvalid}, 8'h01);
        chk8(rdata, exp);
    endtask
    // write then read the same byte back to back
    task automatic wrrd(input logic [16:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk_i);
        we = 1'b0;
        re = 1'b1;
        @(negedge clk_i);
        re = 1'b0;
        chk8(rdata, d);
    endtask
    // cycles up to the next rising edge of a pulse
    task automatic rise(input logic line, output int n);
        logic s, p;
        n = 0;
        p = 1'b1;
        s = 1'b1;
        while (!(s && !p) && n < 5000) begin
            @(posedge clk_i);
            #1;
            p = s;
            s = line ? lp : fp;
            n++;
        end
    endtask
    task automatic setup(input logic [7:0] panel, input logic [1:0] div);
        wr(17'h1FFE4, 8'h00);
        wr(17'h1FFE5, 8'h01);
        wr(17'h1FFE6, 8'h00);
        wr(17'h1FFE8, 8'h00);
        wr(17'h1FFEA, 8'h01);
        wr(17'h1FFE1, panel);
        wr(17'h1FFE2, {6'h30, div});
        wr(17'h1FFE3, 8'h03);
    endtask
    task automatic t_reset();
        for (int o = 1; o < 29; o++) begin
            if (o != 23) rd(17'h1FFE0 + 17'(o), (o == 25) ? gpio_in : 8'h00);
        end
    endtask
    task automatic t_regs();
        wr(17'h1FFE4, 8'h27);
        rd(17'h1FFE4, 8'h27);
        wr(17'h15000, 8'h77);
        rd(17'h15000, 8'h00);
        wr(17'h00000, 8'hA5);
        wr(17'h13FFF, 8'h3C);
        rd(17'h00000, 8'hA5);
        rd(17'h13FFF, 8'h3C);
        wrrd(17'h00010, 8'h96);
    endtask
    task automatic t_palette();
        wr(17'h1FFF5, 8'h05);
        wr(17'h1FFF7, 8'hA0);
        wr(17'h1FFF7, 8'hB0);
        wr(17'h1FFF7, 8'hC0);
        wr(17'h1FFF5, 8'h05);
        rd(17'h1FFF7, 8'hA0);
        rd(17'h1FFF7, 8'hB0);
        rd(17'h1FFF7, 8'hC0);
    endtask
    task automatic t_gpio();
        wr(17'h1FFF8, 8'hF0);
        wr(17'h1FFF9, 8'hA5);
        chk8(gpio_oe, 8'hF0);
        chk8(gpio_out, 8'hA5);
        rd(17'h1FFF9, 8'hAA);
    endtask
    // 8 display plus 32 blank pixels, 2 display plus 1 blank lines
    task automatic t_timing();
        for (int d = 0; d < 4; d++) begin
            setup(8'h23, 2'(d));
            rise(1'b1, c);
            rise(1'b1, c);
            chkn(c, 40 << d);
            rise(1'b0, c);
            rise(1'b0, c);
            chkn(c, 120 << d);
            chkn(fpix, 16);
        end
    endtask
    task automatic t_dual();
        setup(8'h63, 2'h0);
        rise(1'b0, c);
        rise(1'b0, c);
        chkn(c, 160);
    endtask
    task automatic t_stall();
        stall = 1'b1;
        setup(8'h23, 2'h0);
        rise(1'b0, c);
        rise(1'b0, c);
        rise(1'b0, c);
        chkn(fpix, 16);
        stall = 1'b0;
    endtask
    // one bit per pixel, entry 1 shown for the top bit of byte 0
    task automatic t_pixel();
        setup(8'h23, 2'h0);
        wr(17'h1FFF5, 8'h00);
        wr(17'h1FFF7, 8'h10);
        wr(17'h1FFF7, 8'h20);
        wr(17'h1FFF7, 8'h30);
        wr(17'h1FFF7, 8'h40);
        wr(17'h1FFF7, 8'h50);
        wr(17'h1FFF7, 8'h60);
        wr(17'h00000, 8'h80);
        wr(17'h1FFE2, 8'h00);
        rise(1'b0, c);
        rise(1'b0, c);
        chk8(first_pix[11:4], 8'h45);
        chk8({first_pix[3:0], 4'h0}, 8'h60);
    endtask
    task automatic t_mod();
        logic m;
        setup(8'h27, 2'h0);
        rise(1'b0, c);
        m = modl;
        rise(1'b0, c);
        chk8({7'h00, modl}, {7'h00, !m});
        wr(17'h1FFE1, 8'h23);
        chk8({7'h00, modl}, 8'h00);
    endtask
    task automatic t_freeze();
        logic l0, f0;
        @(negedge clk_i);
        ce = 1'b0;
        l0 = lp;
        f0 = fp;
        wr(17'h1FFFA, 8'h3C);
        repeat (40) @(negedge clk_i);
        chk8({6'h00, lp, fp}, {6'h00, l0, f0});
        ce = 1'b1;
        rd(17'h1FFFA, 8'h00);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rstn_i = 1'b1;
        t_reset();
        t_regs();
        t_palette();
        t_gpio();
        t_timing();
        t_dual();
        t_stall();
        t_pixel();
        t_mod();
        t_freeze();
        wrap_up();
    end
    initial begin
        #(25 * 60000);
        error_cnt++;
        wrap_up();
    end
endmodule
`default_nettype wire
